// *** verilog/mcs_call_skip_core.sv ***
// Purpose: Executes indirect call, bit-test-skip-if-set, and clear/invert operations.
// Assumes: A fetch stage presents one decoded instruction per cycle with instrValid.
// Notes: Register file and return stack sit outside; this block drives their write ports.
`timescale 1ns/100ps
`default_nettype none
module mcs_call_skip_core
  import mcs_pkg::*;
(
  // Clock and reset.
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // Decoded instruction.
  input  wire logic                   instrValid,
  input  wire mcs_pkg::mcs_op_e       instrOp,
  input  wire logic [mcs_pkg::FADDR_W-1:0] instrAddr,
  input  wire logic [2:0]             instrBit,
  input  wire logic                   instrDest,
  // Register file and high-page pointer.
  input  wire logic [mcs_pkg::DATA_W-1:0] regRdata,
  input  wire logic [mcs_pkg::DATA_W-1:0] highPagePointer,
  // Register file write port.
  output logic [mcs_pkg::FADDR_W-1:0] regAddr,
  output logic                        regWe,
  output logic [mcs_pkg::DATA_W-1:0]  regWdata,
  // Return stack write port.
  output logic                        stackWe,
  output logic [mcs_pkg::SP_W-1:0]    stackIdx,
  output logic [mcs_pkg::PC_W-1:0]    stackWdata,
  // Core state.
  output logic [mcs_pkg::PC_W-1:0]    pc,
  output logic [mcs_pkg::DATA_W-1:0]  acc,
  output logic                        zeroFlag,
  output logic [mcs_pkg::SP_W-1:0]    stackPtr,
  output logic                        busy
);
  import mcs_pkg::*;

  typedef struct packed {
    mcs_state_e          state;
    logic [PC_W-1:0]     pc;
    logic [DATA_W-1:0]   acc;
    logic                zero;
    logic [SP_W-1:0]     sp;
    logic                stackWe;
    logic [SP_W-1:0]     stackIdx;
    logic [PC_W-1:0]     stackData;
    logic                regWe;
    logic [FADDR_W-1:0]  regAddr;
    logic [DATA_W-1:0]   regData;
  } mcs_core_s;

  mcs_core_s cur;
  mcs_core_s next_cur;

  logic [DATA_W-1:0] exResult;
  logic              exZero;
  logic              exAccWr;
  logic              exRegWr;
  logic              exZeroWr;
  logic              issue;
  mcs_op_e           exOp;

  assign issue = instrValid && (cur.state == MCS_ST_RUN);

  // Feeds the execute unit a no-operation unless an instruction is taken.
  always_comb begin
    exOp = MCS_OP_NOP;
    if (issue) begin
      exOp = instrOp;
    end
  end

  mcs_exec_unit u_exec (
    .op        (exOp),
    .dest      (instrDest),
    .regIn     (regRdata),
    .result    (exResult),
    .zeroOut   (exZero),
    .accWrite  (exAccWr),
    .regWrite  (exRegWr),
    .zeroWrite (exZeroWr)
  );

  function automatic logic [PC_W-1:0] pcInc(input logic [PC_W-1:0] p);
    pcInc = p + 11'h001;
  endfunction

  always_comb begin
    next_cur         = cur;
    next_cur.stackWe = 1'b0;
    next_cur.regWe   = 1'b0;
    case (cur.state)
      MCS_ST_RUN: begin
        if (issue) begin
          next_cur.pc = pcInc(cur.pc);
          case (instrOp)
            MCS_OP_CALL_IND: begin
              next_cur.stackWe   = 1'b1;
              next_cur.stackIdx  = cur.sp;
              next_cur.stackData = pcInc(cur.pc);
              next_cur.sp        = cur.sp + 3'h1;
              next_cur.pc        = {highPagePointer[HP_BITS-1:0], acc};
              next_cur.state     = MCS_ST_CALL2;
            end
            MCS_OP_SKIP_SET: begin
              if (regRdata[instrBit]) begin
                next_cur.state = MCS_ST_SQUASH;
              end
            end
            default: begin
              if (exAccWr) begin
                next_cur.acc = exResult;
              end
              if (exRegWr) begin
                next_cur.regWe   = 1'b1;
                next_cur.regAddr = instrAddr;
                next_cur.regData = exResult;
              end
              if (exZeroWr) begin
                next_cur.zero = exZero;
              end
            end
          endcase
        end
      end
      MCS_ST_CALL2: begin
        next_cur.state = MCS_ST_RUN;
      end
      MCS_ST_SQUASH: begin
        if (instrValid) begin
          next_cur.pc = pcInc(cur.pc);
        end
        next_cur.state = MCS_ST_RUN;
      end
      default: begin
        next_cur.state = MCS_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur           <= '0;
      cur.state     <= MCS_ST_RUN;
      cur.pc        <= PC_RST;
      cur.acc       <= ACC_RST;
      cur.sp        <= SP_RST;
    end else begin
      cur <= next_cur;
    end
  end

  assign pc         = cur.pc;
  assign acc        = cur.acc;
  assign zeroFlag   = cur.zero;
  assign stackPtr   = cur.sp;
  assign stackWe    = cur.stackWe;
  assign stackIdx   = cur.stackIdx;
  assign stackWdata = cur.stackData;
  assign regWe      = cur.regWe;
  assign regAddr    = cur.regAddr;
  assign regWdata   = cur.regData;
  assign busy       = (cur.state != MCS_ST_RUN);

  AST_CALL_PUSH: assert property (@(posedge clk) disable iff (sys_rst)
    issue && instrOp == MCS_OP_CALL_IND |=> stackWe && stackWdata == $past(pc) + 11'h001)
    else $error("Call did not push return address.");

  AST_CALL_TARGET: assert property (@(posedge clk) disable iff (sys_rst)
    issue && instrOp == MCS_OP_CALL_IND |=> pc == {$past(highPagePointer[2:0]), $past(acc)})
    else $error("Call target wrong.");

  AST_SKIP_TAKEN: assert property (@(posedge clk) disable iff (sys_rst)
    issue && instrOp == MCS_OP_SKIP_SET && regRdata[instrBit] |=> busy ##1 !busy)
    else $error("Skip not taken for set bit.");

  AST_SQUASH_NO_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    busy && !$past(busy) && $past(instrOp == MCS_OP_SKIP_SET)
      |=> !regWe && !stackWe && acc == $past(acc))
    else $error("Squashed instruction had an effect.");

  AST_SKIP_NOT_TAKEN: assert property (@(posedge clk) disable iff (sys_rst)
    issue && instrOp == MCS_OP_SKIP_SET && !regRdata[instrBit] |=> !busy)
    else $error("Skip stalled when bit was clear.");

  AST_CLR_ACC: assert property (@(posedge clk) disable iff (sys_rst)
    issue && instrOp == MCS_OP_CLR_ACC |=> acc == 8'h00 && zeroFlag)
    else $error("Accumulator clear failed.");

  AST_CLR_REG: assert property (@(posedge clk) disable iff (sys_rst)
    issue && instrOp == MCS_OP_CLR_REG |=> regWe && regWdata == 8'h00 && zeroFlag
      && regAddr == $past(instrAddr))
    else $error("Register clear failed.");

  AST_INV_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
    issue && instrOp == MCS_OP_INV_REG |=> zeroFlag == ($past(regRdata) == 8'hff))
    else $error("Invert zero flag wrong.");

  AST_INV_DEST: assert property (@(posedge clk) disable iff (sys_rst)
    issue && instrOp == MCS_OP_INV_REG && !instrDest |=> !regWe && acc == ~$past(regRdata))
    else $error("Invert to accumulator failed.");

  AST_SP_ADV: assert property (@(posedge clk) disable iff (sys_rst)
    issue && instrOp == MCS_OP_CALL_IND |=> stackPtr == $past(stackPtr) + 3'h1)
    else $error("Stack pointer did not advance.");

  AST_INV_WRITEBACK: assert property (@(posedge clk) disable iff (sys_rst)
    issue && instrOp == MCS_OP_INV_REG && instrDest |=> regWe && regAddr == $past(instrAddr)
      && regWdata == ~$past(regRdata) && acc == $past(acc))
    else $error("Invert to register failed.");

  AST_SKIP_CONT: assert property (@(posedge clk) disable iff (sys_rst)
    issue && instrOp == MCS_OP_SKIP_SET && !regRdata[instrBit] |=> pc == $past(pc) + 11'h001)
    else $error("Skip with clear bit did not continue.");

  AST_SKIP_PC: assert property (@(posedge clk) disable iff (sys_rst)
    issue && instrOp == MCS_OP_SKIP_SET && regRdata[instrBit] ##1 instrValid
      |=> pc == $past(pc, 2) + 11'h002)
    else $error("Skipped instruction not stepped over.");

  AST_STACK_IDX: assert property (@(posedge clk) disable iff (sys_rst)
    issue && instrOp == MCS_OP_CALL_IND |=> stackIdx == $past(stackPtr))
    else $error("Return address pushed to wrong entry.");
endmodule // mcs_call_skip_core
`default_nettype wire

// *** common/mcs_pkg.sv ***
// Purpose: Shared constants and types for the call, skip and clear execution block.
// Assumes: An 11-bit program counter and 8-bit data path.
// Notes: Opcode values are local encodings presented by the decoder in front of this block.
package mcs_pkg;

  localparam int PC_W    = 11;
  localparam int DATA_W  = 8;
  localparam int FADDR_W = 6;
  localparam int SP_W    = 3;

  localparam logic [PC_W-1:0]   PC_RST  = 11'h000;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [SP_W-1:0]   SP_RST  = 3'h0;
  localparam logic [DATA_W-1:0] CLR_VAL = 8'h00;

  localparam int HP_BITS   = 3;
  localparam int PC_HI_LSB = 8;

  localparam int CALL_CYCLES = 2;
  localparam int SKIP_CYCLES = 2;

  typedef enum logic [2:0] {
    MCS_OP_NOP      = 3'b000,
    MCS_OP_CALL_IND = 3'b001,
    MCS_OP_SKIP_SET = 3'b010,
    MCS_OP_CLR_ACC  = 3'b011,
    MCS_OP_CLR_REG  = 3'b100,
    MCS_OP_INV_REG  = 3'b101
  } mcs_op_e;

  typedef enum logic [1:0] {
    MCS_ST_RUN   = 2'b00,
    MCS_ST_CALL2 = 2'b01,
    MCS_ST_SQUASH = 2'b10
  } mcs_state_e;

endpackage

// *** verilog/mcs_exec_unit.sv ***
// Purpose: Computes the data result and zero flag of clear and invert operations.
// Assumes: Purely combinational, used by the sequencer.
// Notes: For invert, the destination bit selects accumulator or file register.
`timescale 1ns/100ps
`default_nettype none
module mcs_exec_unit
  import mcs_pkg::*;
(
  // Operation.
  input  wire mcs_pkg::mcs_op_e     op,
  input  wire logic                 dest,
  // Operands.
  input  wire logic [mcs_pkg::DATA_W-1:0] regIn,
  // Results.
  output logic [mcs_pkg::DATA_W-1:0] result,
  output logic                      zeroOut,
  output logic                      accWrite,
  output logic                      regWrite,
  output logic                      zeroWrite
);
  import mcs_pkg::*;

  always_comb begin
    result    = CLR_VAL;
    accWrite  = 1'b0;
    regWrite  = 1'b0;
    zeroWrite = 1'b0;
    case (op)
      MCS_OP_CLR_ACC: begin
        accWrite  = 1'b1;
        zeroWrite = 1'b1;
      end
      MCS_OP_CLR_REG: begin
        regWrite  = 1'b1;
        zeroWrite = 1'b1;
      end
      MCS_OP_INV_REG: begin
        result    = ~regIn;
        accWrite  = ~dest;
        regWrite  = dest;
        zeroWrite = 1'b1;
      end
      default: begin
        result = CLR_VAL;
      end
    endcase
  end

  assign zeroOut = (result == CLR_VAL);
endmodule // mcs_exec_unit
`default_nettype wire

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the call, skip and clear execution block.
// Assumes: Inputs change at rising edges; outputs are checked at falling edges.
// Notes: Each check at a falling edge sees the instruction taken one edge earlier.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin totalChecks++; if ((a) !== (e)) begin numErrors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  import mcs_pkg::*;
  typedef struct packed {
    mcs_op_e    op;
    logic [7:0] rd;
    logic [2:0] bt;
    logic       dst;
    logic       we;
    logic [7:0] wd;
    logic [7:0] ac;
    logic       z;
  } mcs_row_s;
  logic clk, sys_rst, instrValid, instrDest, regWe, stackWe, zeroFlag, busy;
  mcs_op_e instrOp;
  logic [5:0] instrAddr, regAddr;
  logic [2:0] instrBit, stackIdx, stackPtr;
  logic [7:0] regRdata, highPagePointer, regWdata, acc;
  logic [10:0] stackWdata, pc;
  int numErrors, totalChecks;
  mcs_row_s rows [7];
  mcs_call_skip_core i_dut (.clk(clk), .sys_rst(sys_rst), .instrValid(instrValid),
    .instrOp(instrOp), .instrAddr(instrAddr), .instrBit(instrBit), .instrDest(instrDest),
    .regRdata(regRdata), .highPagePointer(highPagePointer), .regAddr(regAddr),
    .regWe(regWe), .regWdata(regWdata), .stackWe(stackWe), .stackIdx(stackIdx),
    .stackWdata(stackWdata), .pc(pc), .acc(acc), .zeroFlag(zeroFlag),
    .stackPtr(stackPtr), .busy(busy));
  always #4 clk = ~clk;
  task automatic complete_run();
    if (numErrors == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic step(input mcs_op_e op, input logic [7:0] rd, input logic [2:0] b,
                      input logic d, input logic v, input logic [7:0] hp);
    @(posedge clk);
    instrOp         <= op;
    regRdata        <= rd;
    instrBit        <= b;
    instrDest       <= d;
    instrValid      <= v;
    highPagePointer <= hp;
    @(negedge clk);
  endtask
  initial begin
    #(8 * 2000);
    numErrors++;
    complete_run();
  end
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    instrValid = 1'b0;
    instrOp = MCS_OP_NOP;
    instrAddr = 6'h3f;
    instrBit = 3'h0;
    instrDest = 1'b0;
    regRdata = 8'h00;
    highPagePointer = 8'h00;
    rows = '{'{MCS_OP_CLR_ACC, 8'h00, 3'h0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b1},
             '{MCS_OP_INV_REG, 8'ha6, 3'h0, 1'b1, 1'b1, 8'h59, 8'h00, 1'b0},
             '{MCS_OP_INV_REG, 8'hff, 3'h0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b1},
             '{MCS_OP_INV_REG, 8'h5a, 3'h0, 1'b0, 1'b0, 8'h00, 8'ha5, 1'b0},
             '{MCS_OP_CLR_REG, 8'h77, 3'h0, 1'b0, 1'b1, 8'h00, 8'ha5, 1'b1},
             '{MCS_OP_SKIP_SET, 8'h5a, 3'h2, 1'b0, 1'b0, 8'h00, 8'ha5, 1'b1},
             '{MCS_OP_INV_REG, 8'hcb, 3'h0, 1'b0, 1'b0, 8'h00, 8'h34, 1'b0}};
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    `CHK({pc, acc, zeroFlag, stackPtr, busy, regWe, stackWe}, 26'h0)
    // Ordinary cases: one instruction per row, back to back.
    for (int i = 0; i < 8; i++) begin
      if (i < 7) begin
        step(rows[i].op, rows[i].rd, rows[i].bt, rows[i].dst, 1'b1, 8'h00);
      end else begin
        step(MCS_OP_NOP, 8'h00, 3'h0, 1'b0, 1'b0, 8'h00);
      end
      if (i > 0) begin
        `CHK(pc, 11'(i))
        `CHK(acc, rows[i-1].ac)
        `CHK(zeroFlag, rows[i-1].z)
        `CHK(regWe, rows[i-1].we)
        `CHK({busy, stackWe}, 2'h0)
        if (rows[i-1].we) begin
          `CHK({regAddr, regWdata}, {6'h3f, rows[i-1].wd})
        end
      end
    end
    // Two calls: the upper pointer bits must be ignored.
    step(MCS_OP_CALL_IND, 8'h00, 3'h0, 1'b0, 1'b1, 8'hfa);
    step(MCS_OP_NOP, 8'h00, 3'h0, 1'b0, 1'b0, 8'h00);
    `CHK(pc, 11'h234)
    `CHK({stackWe, stackIdx, stackWdata}, {1'b1, 3'h0, 11'h008})
    `CHK({stackPtr, busy}, {3'h1, 1'b1})
    step(MCS_OP_CALL_IND, 8'h00, 3'h0, 1'b0, 1'b1, 8'h05);
    `CHK({pc, stackWe, busy}, {11'h234, 2'h0})
    step(MCS_OP_NOP, 8'h00, 3'h0, 1'b0, 1'b0, 8'h00);
    `CHK(pc, 11'h534)
    `CHK({stackWe, stackIdx, stackWdata, stackPtr}, {1'b1, 3'h1, 11'h235, 3'h2})
    step(MCS_OP_NOP, 8'h00, 3'h0, 1'b0, 1'b0, 8'h00);
    // Skip taken: the fetched clear must be discarded.
    step(MCS_OP_SKIP_SET, 8'h5a, 3'h3, 1'b0, 1'b1, 8'h00);
    step(MCS_OP_CLR_ACC, 8'h00, 3'h0, 1'b0, 1'b1, 8'h00);
    `CHK({busy, pc}, {1'b1, 11'h535})
    step(MCS_OP_CLR_ACC, 8'h00, 3'h0, 1'b0, 1'b1, 8'h00);
    `CHK({busy, pc, acc, zeroFlag}, {1'b0, 11'h536, 8'h34, 1'b0})
    step(MCS_OP_NOP, 8'h00, 3'h0, 1'b0, 1'b0, 8'h00);
    `CHK({pc, acc, zeroFlag}, {11'h537, 8'h00, 1'b1})
    // Reset again in mid-run, then release it and run one invert.
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    `CHK({pc, acc, zeroFlag, stackPtr, busy, regWe, stackWe}, 26'h0)
    @(posedge clk);
    sys_rst   <= 1'b0;
    instrAddr <= 6'h15;
    step(MCS_OP_INV_REG, 8'h0f, 3'h0, 1'b1, 1'b1, 8'h00);
    step(MCS_OP_NOP, 8'h00, 3'h0, 1'b0, 1'b0, 8'h00);
    `CHK({pc, regWe, regAddr, regWdata, acc}, {11'h001, 1'b1, 6'h15, 8'hf0, 8'h00})
    complete_run();
  end
endmodule // tb_top
`undef CHK
`default_nettype wire
